//--- core/spc_sleep_power_control.v
// Sleep mode control, brownout sleep-off unlock and peripheral clock gating.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "spc_consts.vh"
module spc_sleep_power_control (
    // Clock and reset.
    input  wire       i_core_clk,
    input  wire       i_rstn,
    // Register port.
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // Core events and peripheral status.
    input  wire       i_sleep_instr,
    input  wire       i_wake,
    input  wire       i_timer_two_async_select,
    input  wire       i_conv_enabled,
    input  wire       i_comp_enabled,
    input  wire       i_comp_uses_ref,
    input  wire       i_wdog_enabled,
    input  wire       i_brownout_level_fuses,
    input  wire       i_debug_enable_fuse,
    // Sleep state.
    output reg        o_asleep,
    output reg  [2:0] o_sleep_mode,
    output reg        o_brownout_detector_en,
    output reg        o_brownout_sleep_off,
    // Clock enables for gated peripherals.
    output reg        o_clk_en_two_wire,
    output reg        o_clk_en_timer_two,
    output reg        o_clk_en_timer_zero,
    output reg        o_clk_en_timer_one,
    output reg        o_clk_en_serial_periph,
    output reg        o_clk_en_async_serial,
    output reg        o_clk_en_converter,
    // Sleep-time controls of analog and other units.
    output reg        o_conv_extended_next,
    output reg        o_comp_mux_block,
    output reg        o_comp_enable,
    output reg        o_input_buf_disable,
    output reg        o_wdog_run,
    output reg        o_main_clk_run,
    output reg        o_cpu_clk_en,
    output reg        o_io_clk_en,
    output reg        o_periph_reg_block
);

    reg  [2:0] sleep_mode_select_q;
    reg        sleep_arm_q;
    reg  [7:0] pcg_q;
    reg  [2:0] unlock_cnt_q;
    reg  [2:0] off_cnt_q;
    reg        asleep_q;
    reg        bod_off_sleep_q;
    reg        conv_was_on_q;
    reg        conv_restart_q;

    wire wr_smc = i_wr && (i_addr == `SPC_ADDR_SMC);
    wire wr_ucr = i_wr && (i_addr == `SPC_ADDR_UCR);
    wire wr_pcg = i_wr && (i_addr == `SPC_ADDR_PCG);

    // Unlock-pair write opens a four-cycle window; a lone set write inside it arms sleep-off.
    wire unlock_wr = wr_ucr && i_wdata[`SPC_UCR_OFF_BIT] && i_wdata[`SPC_UCR_UNLK_BIT];
    wire set_wr    = wr_ucr && i_wdata[`SPC_UCR_OFF_BIT] && !i_wdata[`SPC_UCR_UNLK_BIT]
                     && (unlock_cnt_q != 3'h0);
    // Bit is visible at once and self-clears after three cycles; effective on cycles 3..5.
    wire bod_bit    = (off_cnt_q != 3'h0) && (off_cnt_q > `SPC_OFF_DELAY_CYC);
    wire bod_active = (off_cnt_q != 3'h0) && (off_cnt_q <= `SPC_OFF_DELAY_CYC);

    // True for every mode other than idle and noise, reserved modes included.
    function deep_mode;
        input [2:0] m;
        begin
            deep_mode = (m != `SPC_MODE_IDLE) && (m != `SPC_MODE_NOISE);
        end
    endfunction

    wire go_sleep = i_sleep_instr && sleep_arm_q && !asleep_q;

    // Register writes; reserved bits are masked so they never store.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sleep_mode_select_q <= 3'h0;
            sleep_arm_q         <= 1'b0;
            pcg_q               <= `SPC_RST_VAL;
        end else begin
            if (wr_smc) begin
                sleep_mode_select_q <= i_wdata[3:1];
                sleep_arm_q         <= i_wdata[0];
            end
            if (wr_pcg) begin
                pcg_q <= i_wdata & `SPC_PCG_MASK;
            end
        end
    end

    // Timed unlock and sleep-off life counters.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            unlock_cnt_q <= 3'h0;
            off_cnt_q    <= 3'h0;
        end else begin
            if (unlock_wr) begin
                unlock_cnt_q <= `SPC_UNLOCK_CYC;
            end else if (set_wr) begin
                unlock_cnt_q <= 3'h0;
            end else if (unlock_cnt_q != 3'h0) begin
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            end
            if (set_wr) begin
                off_cnt_q <= `SPC_OFF_LIFE_CYC;
            end else if (off_cnt_q != 3'h0) begin
                off_cnt_q <= off_cnt_q - 3'h1;
            end
        end
    end

    // Sleep state; detector switch-off is latched only at sleep entry.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            asleep_q        <= 1'b0;
            bod_off_sleep_q <= 1'b0;
        end else if (go_sleep) begin
            asleep_q        <= 1'b1;
            bod_off_sleep_q <= bod_active && deep_mode(sleep_mode_select_q);
        end else if (i_wake) begin
            asleep_q        <= 1'b0;
            bod_off_sleep_q <= 1'b0;
        end
    end

    // Converter power tracking: an off-then-on cycle flags an extended conversion.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_was_on_q  <= 1'b0;
            conv_restart_q <= 1'b0;
        end else begin
            conv_was_on_q <= i_conv_enabled && !pcg_q[`SPC_PG_ADC];
            if (i_conv_enabled && !pcg_q[`SPC_PG_ADC] && !conv_was_on_q) begin
                conv_restart_q <= 1'b1;
            end else if (!i_conv_enabled) begin
                conv_restart_q <= 1'b0;
            end
        end
    end

    // Registered outputs; gated peripherals, timer two unless async, hold their clock low so state freezes; any set gating bit raises o_periph_reg_block.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata                <= 8'h00;
            o_asleep               <= 1'b0;
            o_sleep_mode           <= 3'h0;
            o_brownout_detector_en <= 1'b0;
            o_brownout_sleep_off   <= 1'b0;
            o_clk_en_two_wire      <= 1'b1;
            o_clk_en_timer_two     <= 1'b1;
            o_clk_en_timer_zero    <= 1'b1;
            o_clk_en_timer_one     <= 1'b1;
            o_clk_en_serial_periph <= 1'b1;
            o_clk_en_async_serial  <= 1'b1;
            o_clk_en_converter     <= 1'b1;
            o_conv_extended_next   <= 1'b0;
            o_comp_mux_block       <= 1'b0;
            o_comp_enable          <= 1'b0;
            o_input_buf_disable    <= 1'b0;
            o_wdog_run             <= 1'b0;
            o_main_clk_run         <= 1'b1;
            o_cpu_clk_en           <= 1'b1;
            o_io_clk_en            <= 1'b1;
            o_periph_reg_block     <= 1'b0;
        end else begin
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `SPC_ADDR_SMC: o_rdata <= {4'h0, sleep_mode_select_q, sleep_arm_q};
                    `SPC_ADDR_UCR: o_rdata <= {1'b0, bod_bit, 6'h00};
                    `SPC_ADDR_PCG: o_rdata <= pcg_q;
                    default:       o_rdata <= 8'h00;
                endcase
            end
            o_asleep             <= asleep_q;
            o_sleep_mode         <= sleep_mode_select_q;
            o_brownout_sleep_off <= bod_active;
            o_brownout_detector_en <= i_brownout_level_fuses && !bod_off_sleep_q;
            o_clk_en_two_wire      <= !pcg_q[`SPC_PG_TWI];
            o_clk_en_timer_two     <= !(pcg_q[`SPC_PG_TIM2] && !i_timer_two_async_select);
            o_clk_en_timer_zero    <= !pcg_q[`SPC_PG_TIM0];
            o_clk_en_timer_one     <= !pcg_q[`SPC_PG_TIM1];
            o_clk_en_serial_periph <= !pcg_q[`SPC_PG_SPI];
            o_clk_en_async_serial  <= !pcg_q[`SPC_PG_USART];
            // Converter clock is not stopped by sleep while the converter is enabled.
            o_clk_en_converter     <= !pcg_q[`SPC_PG_ADC];
            o_conv_extended_next   <= conv_restart_q;
            o_comp_mux_block       <= pcg_q[`SPC_PG_ADC];
            o_comp_enable          <= i_comp_enabled &&
                                      (!(asleep_q && deep_mode(sleep_mode_select_q))
                                       || i_comp_uses_ref);
            o_input_buf_disable    <= asleep_q && deep_mode(sleep_mode_select_q);
            o_wdog_run             <= i_wdog_enabled;
            o_main_clk_run         <= !asleep_q || i_debug_enable_fuse
                                      || (sleep_mode_select_q == `SPC_MODE_IDLE)
                                      || (sleep_mode_select_q == `SPC_MODE_NOISE)
                                      || (sleep_mode_select_q == `SPC_MODE_STBY)
                                      || (sleep_mode_select_q == `SPC_MODE_XSTBY);
            o_cpu_clk_en           <= !asleep_q;
            o_io_clk_en            <= !asleep_q || (sleep_mode_select_q == `SPC_MODE_IDLE);
            o_periph_reg_block     <= |pcg_q;
        end
    end

endmodule

//--- common/spc_consts.vh
// Constants for the sleep and power control block.
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_ADDR_SMC        8'h33
`define SPC_ADDR_UCR        8'h35
`define SPC_ADDR_PCG        8'h64
`define SPC_SMC_MASK        8'h0F
`define SPC_PCG_MASK        8'hEF
`define SPC_RST_VAL         8'h00
`define SPC_UCR_OFF_BIT     6
`define SPC_UCR_UNLK_BIT    5
`define SPC_MODE_IDLE       3'h0
`define SPC_MODE_NOISE      3'h1
`define SPC_MODE_PDOWN      3'h2
`define SPC_MODE_PSAVE      3'h3
`define SPC_MODE_STBY       3'h6
`define SPC_MODE_XSTBY      3'h7
`define SPC_UNLOCK_CYC      3'h4
`define SPC_OFF_DELAY_CYC   2'h3
`define SPC_OFF_LIFE_CYC    3'h6
`define SPC_PG_TWI          7
`define SPC_PG_TIM2         6
`define SPC_PG_TIM0         5
`define SPC_PG_TIM1         3
`define SPC_PG_SPI          2
`define SPC_PG_USART        1
`define SPC_PG_ADC          0
`endif

//--- testbench/spc_props.sv
// Concurrent checks on the ports of the sleep and power control block.
`timescale 1ns/10ps
module spc_props (
    // Clock, reset and register port.
    input logic       i_core_clk, i_rstn, i_wr, i_rd,
    input logic [7:0] i_addr, i_wdata, o_rdata,
    // Sleep state, comparator and gating outputs.
    input logic       i_sleep_instr, i_comp_uses_ref, o_asleep, o_brownout_sleep_off,
    input logic [2:0] o_sleep_mode,
    input logic       o_clk_en_two_wire, o_comp_mux_block, o_comp_enable, o_input_buf_disable
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // The two halves of the timed unlock, and a settled deep sleep.
    sequence s_unlock; i_wr && i_addr == 8'h35 && i_wdata[6:5] == 2'b11; endsequence
    sequence s_set; i_wr && i_addr == 8'h35 && i_wdata[6:5] == 2'b10; endsequence
    sequence s_deep; o_asleep && $past(o_asleep) && o_sleep_mode > 3'h1; endsequence
    property p_smc_rsvd; $past(i_rd) && $past(i_addr) == 8'h33 |-> o_rdata[7:4] == 4'h0; endproperty
    property p_pcg_rsvd; $past(i_rd) && $past(i_addr) == 8'h64 |-> !o_rdata[4]; endproperty
    property p_arm; $rose(o_asleep) |-> $past(i_sleep_instr) || $past(i_sleep_instr, 2); endproperty
    property p_bso_delay;
        s_unlock ##[1:4] s_set |-> !o_brownout_sleep_off [*4] ##[1:2] o_brownout_sleep_off;
    endproperty
    property p_bso_clear;
        $rose(o_brownout_sleep_off) |-> o_brownout_sleep_off [*3] ##1 !o_brownout_sleep_off;
    endproperty
    property p_twi; i_wr && i_addr == 8'h64 |-> ##2 o_clk_en_two_wire == !$past(i_wdata[7], 2);
    endproperty
    property p_mux; i_wr && i_addr == 8'h64 |-> ##2 o_comp_mux_block == $past(i_wdata[0], 2);
    endproperty
    property p_buf; s_deep |-> o_input_buf_disable; endproperty
    property p_comp; s_deep and !$past(i_comp_uses_ref) |-> !o_comp_enable; endproperty
    a_smc_rsvd: assert property (p_smc_rsvd) else $error("sleep control upper bits not zero");
    a_pcg_rsvd: assert property (p_pcg_rsvd) else $error("gating bit four not zero");
    a_arm: assert property (p_arm) else $error("sleep without a sleep request");
    a_bso_delay: assert property (p_bso_delay) else $error("sleep-off delay wrong");
    a_bso_clear: assert property (p_bso_clear) else $error("sleep-off length wrong");
    a_twi: assert property (p_twi) else $error("two-wire clock enable wrong");
    a_mux: assert property (p_mux) else $error("comparator mux block wrong");
    a_buf: assert property (p_buf) else $error("input buffers on in deep sleep");
    a_comp: assert property (p_comp) else $error("comparator on in deep sleep");
endmodule
bind spc_sleep_power_control spc_props spc_props_i (.i_core_clk, .i_rstn, .i_wr, .i_rd,
    .i_addr, .i_wdata, .o_rdata, .i_sleep_instr, .i_comp_uses_ref, .o_asleep,
    .o_brownout_sleep_off, .o_sleep_mode, .o_clk_en_two_wire, .o_comp_mux_block,
    .o_comp_enable, .o_input_buf_disable);

//--- testbench/spc_core_model.sv
// Processor core model: issues the sleep instruction and a later wake event.
`timescale 1ns/10ps
module spc_core_model (
    // Clock, reset and request from the bench.
    input  logic       i_clk,
    input  logic       i_rstn,
    input  logic       i_go,
    input  logic [3:0] i_dwell,
    // Core events.
    output logic       o_sleep_instr,
    output logic       o_wake
);
    logic [4:0] cnt_q;
    // The bench arms just before a request; the dwell sets how slowly wake arrives.
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 5'h00;
            o_sleep_instr <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_sleep_instr <= i_go;
            o_wake <= (cnt_q == 5'h01);
            cnt_q <= i_go ? {1'b0, i_dwell} + 5'h02 : cnt_q - {4'h0, cnt_q != 5'h00};
        end
    end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the sleep and power control block.
`timescale 1ns/10ps
module testbench;
    logic       i_core_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
    logic       asel = 1'b0, conv = 1'b0, cref = 1'b0, wdog = 1'b0, dbg = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, d;
    logic [3:0] dwell = 4'h5;
    wire  [7:0] o_rdata;
    wire  [6:0] cen;
    wire  [2:0] o_sleep_mode;
    wire        sleep_instr, wake, o_asleep, o_brownout_detector_en, o_brownout_sleep_off;
    wire        o_comp_mux_block, o_comp_enable, o_input_buf_disable, o_wdog_run;
    wire        o_main_clk_run, o_periph_reg_block;
    wire        o_cpu_clk_en, o_io_clk_en, o_conv_extended_next;
    integer     seed = 43939, err_total = 0, tests_run = 0, cyc = 0, m;
    always #5 i_core_clk = ~i_core_clk;
    spc_sleep_power_control spc_sleep_power_control_i (.i_core_clk, .i_rstn, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep_instr(sleep_instr), .i_wake(wake),
        .i_timer_two_async_select(asel), .i_conv_enabled(conv), .i_comp_enabled(1'b1),
        .i_comp_uses_ref(cref), .i_wdog_enabled(wdog), .i_brownout_level_fuses(1'b1),
        .i_debug_enable_fuse(dbg), .o_asleep, .o_sleep_mode, .o_brownout_detector_en,
        .o_brownout_sleep_off, .o_clk_en_two_wire(cen[6]), .o_clk_en_timer_two(cen[5]),
        .o_clk_en_timer_zero(cen[4]), .o_clk_en_timer_one(cen[3]),
        .o_clk_en_serial_periph(cen[2]), .o_clk_en_async_serial(cen[1]),
        .o_clk_en_converter(cen[0]), .o_conv_extended_next, .o_comp_mux_block,
        .o_comp_enable, .o_input_buf_disable, .o_wdog_run, .o_main_clk_run,
        .o_cpu_clk_en, .o_io_clk_en, .o_periph_reg_block);
    spc_core_model spc_core_model_i (.i_clk(i_core_clk), .i_rstn, .i_go(go),
        .i_dwell(dwell), .o_sleep_instr(sleep_instr), .o_wake(wake));
    // Expected read-back: reserved bits drop out, unit control reads zero when not unlocked.
    function automatic logic [7:0] f_rd(input logic [7:0] a, input logic [7:0] v);
        f_rd = (a == 8'h33) ? (v & 8'h0f) : (a == 8'h64) ? (v & 8'hef) : 8'h00;
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("errors %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_core_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
        @(posedge i_core_clk) i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_core_clk) {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_core_clk) i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    // Request a sleep, then look once the state has settled.
    task sleep_go;
        @(posedge i_core_clk) go <= 1'b1;
        @(posedge i_core_clk) go <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        #1;
    endtask
    // A hung run is cut short and counted as a failure.
    always @(posedge i_core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        for (m = 0; m < 4; m++) rd(m[1] ? (m[0] ? 8'h40 : 8'h64) : 8'h33 + m[7:0] * 2, 8'h00);
        repeat (24) begin
            d = $random(seed);
            asel <= d[4];
            conv <= d[0] ? 1'b0 : d[2];
            wr(8'h33, d);
            rd(8'h33, f_rd(8'h33, d));
            chk(o_sleep_mode, d[3:1]);
            wr(8'h64, d);
            rd(8'h64, f_rd(8'h64, d));
            chk({1'b0, cen}, {1'b0, ~{d[7], d[6] & ~asel, d[5], d[3:0]}});
            chk(o_conv_extended_next, conv);
            chk(o_periph_reg_block, |(d & 8'hef));
            chk(o_comp_mux_block, d[0]);
            wr(8'h35, d);
            rd(8'h35, 8'h00);
        end
        wr(8'h64, 8'h00);
        wr(8'h33, 8'h04);
        sleep_go;
        chk(o_asleep, 1'b0);
        for (m = 0; m < 8; m++) begin
            {wdog, dbg, cref} <= {m[1], m[0], m[2]};
            dwell <= 4'h5 + m[3:0];
            wr(8'h33, {m[2:0], 1'b1});
            sleep_go;
            chk(o_sleep_mode, m[2:0]);
            if (m != 4 && m != 5) begin
                chk(o_asleep, 1'b1);
                chk(o_input_buf_disable, m > 1);
                chk(o_comp_enable, m < 2 || m > 5);
                chk(o_main_clk_run, dbg || m < 2 || m > 5);
                chk({o_wdog_run, o_brownout_detector_en}, {wdog, 1'b1});
                chk(o_cpu_clk_en, 1'b0);
                chk(o_io_clk_en, m == 0);
            end
            // Reserved modes still sleep, so every pass waits for the wake event.
            repeat (20) @(posedge i_core_clk);
            #1 chk(o_asleep, 1'b0);
        end
        // A late second write is refused; a timely one sets the bit briefly.
        wr(8'h35, 8'h60);
        repeat (3) @(posedge i_core_clk);
        wr(8'h35, 8'h40);
        rd(8'h35, 8'h00);
        wr(8'h35, 8'h60);
        wr(8'h35, 8'h40);
        rd(8'h35, 8'h40);
        rd(8'h35, 8'h00);
        wr(8'h33, 8'h05);
        wr(8'h35, 8'h60);
        wr(8'h35, 8'h40);
        repeat (2) @(posedge i_core_clk);
        sleep_go;
        chk(o_brownout_detector_en, 1'b0);
        repeat (25) @(posedge i_core_clk);
        #1 chk(o_brownout_detector_en, 1'b1);
        tally_and_finish;
    end
endmodule
